//--- design/fewp_pkg.sv
// Purpose: constants and types for the flash erase / write-protect command block
// Assumes: one 125 MHz clock, SPI pins sampled by that clock
// Notes: opcode of the status write and its data bit layout are local choices
// Notes on behaviour
// - opcodes 60h, 62h and C7h all start the same whole-array erase.
// - whole-array erase runs only if the write-enable latch was already set.
// - erase takes no address, ignores trailing bytes, starts at chip select release.
// - erase needs chip select released on a byte boundary; otherwise no erase, latch cleared.
// - erase while array protected does nothing but clear the write-enable latch.
// - busy shows during erase; write-enable latch clears before erase ends.
// - failed internal erase verify sets the erase/program error flag.
// - write-enable opcode 06h sets the latch at chip select release.
// - program, erase and status write commands are refused without the latch set.
// - write-disable opcode 04h clears the latch at chip select release.
// - enable/disable released off a byte boundary abort, latch unchanged.
// - array-protect bit set protects the whole array from program and erase.
// - array-protect bit changes only through the status write command.
// - array-protect bit survives power cycles; shipped value is zero. Here reset reloads zero.
// - write-protect pin low with lock bit set freezes both bits, status writes ignored.
// - with write-protect low, a set lock bit stays set until power cycle.
// - lock bit at zero may be set regardless of the write-protect pin.
// - write-protect high with lock set leaves protect writable and lock clearable.
package fewp_pkg;
    localparam logic [7:0] OP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_ERASE_B = 8'h62;
    localparam logic [7:0] OP_ERASE_C = 8'hc7;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam int WRS_PROTECT_POS = 2;
    localparam int WRS_LOCK_POS = 7;
    localparam logic RST_PROTECT = 1'b0;
    localparam logic RST_LOCK = 1'b0;
    localparam logic RST_WEL = 1'b0;
    localparam int CLOCK_MHZ = 125;
    localparam int ERASE_TIME_US_DEF = 1000;

    typedef struct packed {
        logic sck;
        logic csN;
        logic mosi;
    } fewp_spi_t;

    typedef struct packed {
        logic busy;
        logic eraseProgramError;
        logic protectLock;
        logic hwLocked;
        logic arrayProtect;
        logic writeEnableLatch;
    } fewp_status_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_VERIFY = 2'b11
    } fewp_state_t;
endpackage : fewp_pkg

//--- design/fewp_flash_erase_write_protect.sv
// Purpose: chip erase, write enable/disable and protection locking command logic
// Assumes: pins asynchronous to clock; serial clock well below a quarter of clock
// Notes: array erase itself is outside; this block starts it and times it
`timescale 1ns/10ps
module fewp_flash_erase_write_protect
    import fewp_pkg::*;
#(
    parameter int ERASE_TIME_US = ERASE_TIME_US_DEF
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire fewp_spi_t spiPins,
    input wire logic writeProtectN,
    input wire logic eraseVerifyFail,
    output logic eraseStart,
    output fewp_status_t status
);
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;

    fewp_spi_t syncA;
    fewp_spi_t syncB;
    logic sckLast;
    logic csLast;
    logic wpA;
    logic wpB;
    logic [2:0] bitCount;
    logic [1:0] byteCount;
    logic [7:0] shiftReg;
    logic [7:0] opcode;
    logic [7:0] dataByte;
    fewp_state_t state;
    logic [31:0] eraseTimer;
    logic writeEnableLatch;
    logic arrayProtect;
    logic protectLock;
    logic eraseProgramError;
    logic sckRise;
    logic frameEnd;
    logic aligned;
    logic hwLocked;
    logic isErase;
    logic idle;
    logic [7:0] next_shift;
    logic cmdDone;
    logic eraseGo;
    logic eraseDrop;
    logic wenGo;
    logic wdiGo;
    logic wrsGo;
    logic wrsApply;

    function automatic logic is_erase_op(input logic [7:0] op);
        is_erase_op = (op == OP_ERASE_A) || (op == OP_ERASE_B) || (op == OP_ERASE_C);
    endfunction : is_erase_op

    // status write needs opcode, one whole data byte and a byte boundary
    function automatic logic is_status_write(input logic [7:0] op, input logic [1:0] nBytes,
                                             input logic al);
        is_status_write = (op == OP_WR_STATUS) && al && (nBytes >= 2'h2);
    endfunction : is_status_write

    // two-stage synchronisers on every pin
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syncA <= '{sck: 1'b0, csN: 1'b1, mosi: 1'b0};
            syncB <= '{sck: 1'b0, csN: 1'b1, mosi: 1'b0};
            wpA <= 1'b1;
            wpB <= 1'b1;
        end
        else
        begin
            syncA <= spiPins;
            syncB <= syncA;
            wpA <= writeProtectN;
            wpB <= wpA;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sckLast <= 1'b0;
            csLast <= 1'b1;
        end
        else
        begin
            sckLast <= syncB.sck;
            csLast <= syncB.csN;
        end
    end

    assign sckRise = syncB.sck && !sckLast && !syncB.csN;
    assign frameEnd = syncB.csN && !csLast;
    assign aligned = (bitCount == 3'h0) && (byteCount != 2'h0);
    assign hwLocked = !wpB && protectLock;
    assign isErase = is_erase_op(opcode);
    assign idle = (state == ST_IDLE);
    assign next_shift = {shiftReg[6:0], syncB.mosi};

    // bit and byte framing, msb first
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bitCount <= 3'h0;
            byteCount <= 2'h0;
        end
        else if (syncB.csN)
        begin
            bitCount <= 3'h0;
            byteCount <= 2'h0;
        end
        else if (sckRise)
        begin
            bitCount <= bitCount + 3'h1;
            // byte count saturates; bytes past the data byte are ignored
            if (bitCount == 3'h7 && byteCount != 2'h3)
            begin
                byteCount <= byteCount + 2'h1;
            end
        end
    end

    // shift register and captured opcode and data byte
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shiftReg <= 8'h00;
            opcode <= 8'h00;
            dataByte <= 8'h00;
        end
        else if (sckRise)
        begin
            shiftReg <= next_shift;
            if (bitCount == 3'h7 && byteCount == 2'h0)
            begin
                opcode <= next_shift;
            end
            if (bitCount == 3'h7 && byteCount == 2'h1)
            begin
                dataByte <= next_shift;
            end
        end
    end

    // command decode at chip select release; frames under eight bits do nothing
    always_comb
    begin
        cmdDone = frameEnd && idle && (byteCount != 2'h0);
        eraseGo = 1'b0;
        eraseDrop = 1'b0;
        wenGo = 1'b0;
        wdiGo = 1'b0;
        wrsGo = 1'b0;
        if (cmdDone)
        begin
            if (isErase)
            begin
                if (!aligned)
                begin
                    eraseDrop = 1'b1;
                end
                else if (writeEnableLatch && arrayProtect)
                begin
                    eraseDrop = 1'b1;
                end
                else if (writeEnableLatch)
                begin
                    eraseGo = 1'b1;
                end
            end
            else if (aligned && opcode == OP_WR_ENABLE)
            begin
                wenGo = 1'b1;
            end
            else if (aligned && opcode == OP_WR_DISABLE)
            begin
                wdiGo = 1'b1;
            end
            else if (is_status_write(opcode, byteCount, aligned))
            begin
                // costs the latch even when locked
                wrsGo = 1'b1;
            end
        end
    end

    assign wrsApply = wrsGo && writeEnableLatch && !hwLocked;

    // write-enable latch
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            writeEnableLatch <= RST_WEL;
        end
        else if (eraseStart)
        begin
            writeEnableLatch <= 1'b0;
        end
        else if (eraseGo)
        begin
            // cleared at launch so busy never shows beside a set latch
            writeEnableLatch <= 1'b0;
        end
        else if (eraseDrop)
        begin
            writeEnableLatch <= 1'b0;
        end
        else if (wdiGo)
        begin
            writeEnableLatch <= 1'b0;
        end
        else if (wrsGo)
        begin
            writeEnableLatch <= 1'b0;
        end
        else if (wenGo)
        begin
            writeEnableLatch <= 1'b1;
        end
    end

    // protection bits; reset models power cycle, protect value as shipped
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arrayProtect <= RST_PROTECT;
            protectLock <= RST_LOCK;
        end
        else if (wrsApply)
        begin
            arrayProtect <= dataByte[WRS_PROTECT_POS];
            if (!protectLock)
            begin
                protectLock <= dataByte[WRS_LOCK_POS];
            end
            else if (wpB)
            begin
                protectLock <= dataByte[WRS_LOCK_POS];
            end
        end
    end

    // erase start decision
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            eraseStart <= 1'b0;
        end
        else
        begin
            eraseStart <= eraseGo;
        end
    end

    // self-timed erase sequence
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
            eraseTimer <= 32'h0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (eraseStart)
                    begin
                        state <= ST_ERASE;
                        eraseTimer <= 32'(ERASE_CYCLES - 1);
                    end
                end
                ST_ERASE:
                begin
                    if (eraseTimer == 32'h0)
                    begin
                        state <= ST_VERIFY;
                    end
                    else
                    begin
                        eraseTimer <= eraseTimer - 32'h1;
                    end
                end
                ST_VERIFY:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // error flag: set on verify fail, cleared when a new erase starts
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            eraseProgramError <= 1'b0;
        end
        else if (state == ST_VERIFY && eraseVerifyFail)
        begin
            eraseProgramError <= 1'b1;
        end
        else if (eraseStart)
        begin
            eraseProgramError <= 1'b0;
        end
    end

    // status image; busy covers the cycle of the start pulse too
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status <= '0;
        end
        else
        begin
            status.busy <= eraseStart || (state != ST_IDLE);
            status.eraseProgramError <= eraseProgramError;
            status.protectLock <= protectLock;
            status.hwLocked <= hwLocked;
            status.arrayProtect <= arrayProtect;
            status.writeEnableLatch <= writeEnableLatch;
        end
    end
endmodule : fewp_flash_erase_write_protect

//--- bench/fewp_chk.sv
// Purpose: port checks for the erase and protect command block
// Assumes: bound into every instance of the block
// Notes: status lags internal state by one cycle
`timescale 1ns/10ps
module fewp_chk
    import fewp_pkg::*;
#(
    parameter int ERASE_TIME_US = 1
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire fewp_spi_t spiPins,
    input wire logic writeProtectN,
    input wire logic eraseVerifyFail,
    input wire logic eraseStart,
    input wire fewp_status_t status
);
    localparam int BUSY_HOLD = ERASE_TIME_US * CLOCK_MHZ + 1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_start_pulse: assert property (eraseStart |=> !eraseStart)
        else $error("erase start longer than one cycle");
    a_start_gate: assert property (eraseStart |-> status.writeEnableLatch &&
        !status.arrayProtect && !status.busy) else $error("erase started when refused");
    a_busy_wel: assert property (eraseStart |=> status.busy && !status.writeEnableLatch)
        else $error("busy or latch wrong after erase start");
    a_busy_len: assert property ($rose(status.busy) |->
        ##BUSY_HOLD status.busy ##1 !status.busy) else $error("busy length wrong");
    a_busy_nowel: assert property (status.busy |-> !status.writeEnableLatch)
        else $error("latch set while busy");
    a_lock_freeze: assert property (status.hwLocked |=>
        $stable(status.arrayProtect) && $stable(status.protectLock))
        else $error("protection bits changed while locked");
    a_lock_def: assert property (!status.protectLock |-> !status.hwLocked)
        else $error("locked without lock bit");
    a_err_clear: assert property (eraseStart |-> ##2 !status.eraseProgramError)
        else $error("error flag not cleared by new erase");
    a_err_hold: assert property (status.eraseProgramError && !eraseStart &&
        !$past(eraseStart) |=> status.eraseProgramError) else $error("error flag lost");
    c_erase: cover property (eraseStart);
    c_locked: cover property (status.hwLocked);
    c_error: cover property ($rose(status.eraseProgramError));
endmodule : fewp_chk
bind fewp_flash_erase_write_protect fewp_chk #(.ERASE_TIME_US(ERASE_TIME_US)) i_chk (
    .clock(clock), .arst_n(arst_n), .spiPins(spiPins), .writeProtectN(writeProtectN),
    .eraseVerifyFail(eraseVerifyFail), .eraseStart(eraseStart), .status(status));

//--- bench/fewp_spi_host.sv
// Purpose: spi host model sending command frames
// Assumes: 160 ns serial clock, modes 0 and 3
// Notes: frames of any bit count for refusal cases
`timescale 1ns/10ps
module fewp_spi_host
    import fewp_pkg::*;
(
    input wire logic clock,
    input wire logic mode3,
    output fewp_spi_t spi
);
    initial spi = 3'b010;
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_clk
    task automatic frame(input logic [15:0] d, input int n);
        wait_clk(1);
        spi.sck <= mode3;
        wait_clk(9);
        spi.csN <= 1'b0;
        wait_clk(10);
        for (int i = 0; i < n; i++)
        begin
            spi.sck <= 1'b0;
            spi.mosi <= d[15 - i];
            wait_clk(10);
            spi.sck <= 1'b1;
            wait_clk(10);
        end
        spi.sck <= mode3;
        // released line shows no stale bit
        spi.mosi <= ~spi.mosi;
        spi.csN <= 1'b1;
        wait_clk(10);
    endtask : frame
endmodule : fewp_spi_host

//--- bench/fewp_flash_erase_write_protect_tb_top.sv
// Purpose: command sequence test of the erase and protect block
// Assumes: erase time shortened to one microsecond
// Notes: status word busy, error, lock, locked, protect, latch
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    $display("unexpected %s expected %h seen %h", nm, ex, got); num_errors++; end end
module fewp_flash_erase_write_protect_tb_top
    import fewp_pkg::*;
;
    logic clock = 0;
    logic arst_n = 0;
    logic writeProtectN = 1;
    logic eraseVerifyFail = 0;
    logic mode3 = 0;
    logic eraseStart;
    fewp_status_t status;
    fewp_spi_t spiPins;
    int num_errors = 0;
    int n_tests = 0;
    int starts = 0;
    logic [7:0] erOp [3] = '{OP_ERASE_A, OP_ERASE_B, OP_ERASE_C};
    initial forever #4 clock = ~clock;
    fewp_flash_erase_write_protect #(.ERASE_TIME_US(1)) i_dut (.clock(clock),
        .arst_n(arst_n), .spiPins(spiPins), .writeProtectN(writeProtectN),
        .eraseVerifyFail(eraseVerifyFail), .eraseStart(eraseStart), .status(status));
    fewp_spi_host i_host (.clock(clock), .mode3(mode3), .spi(spiPins));
    always @(posedge clock)
        if (eraseStart === 1'b1)
            starts <= starts + 1;
    task automatic end_of_test();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic cmd(input logic [15:0] d, input int n, input logic [5:0] ex);
        i_host.frame(d, n);
        `CHK("status", ex, status)
    endtask : cmd
    task automatic wait_idle();
        for (int i = 0; i < 400 && status.busy !== 1'b0; i++)
            @(negedge clock);
    endtask : wait_idle
    initial
    begin
        repeat (10) @(negedge clock);
        arst_n <= 1'b1;
        repeat (5) @(negedge clock);
        `CHK("status", 6'h00, status)
        cmd(16'h0600, 8, 6'h01);
        cmd(16'h0400, 12, 6'h01);
        cmd(16'h04ff, 16, 6'h00);
        cmd(16'h06ff, 16, 6'h01);
        cmd(16'h0400, 8, 6'h00);
        cmd(16'h6000, 8, 6'h00);
        for (int k = 0; k < 3; k++)
        begin
            mode3 <= k[0];
            eraseVerifyFail <= (k == 0);
            cmd(16'h0600, 8, (k == 1) ? 6'h11 : 6'h01);
            cmd({erOp[k], 8'ha5}, (k == 1) ? 16 : 8, 6'h20);
            wait_idle();
            `CHK("error", k == 0, status.eraseProgramError)
            `CHK("starts", k + 1, starts)
        end
        eraseVerifyFail <= 1'b0;
        cmd(16'h0600, 8, 6'h01);
        cmd(16'h6000, 12, 6'h00);
        cmd(16'h0600, 8, 6'h01);
        cmd(16'h6200, 5, 6'h01);
        cmd(16'h0104, 16, 6'h02);
        cmd(16'h0600, 8, 6'h03);
        cmd(16'hc700, 8, 6'h02);
        `CHK("starts", 3, starts)
        cmd(16'h0100, 16, 6'h02);
        writeProtectN <= 1'b0;
        cmd(16'h0600, 8, 6'h03);
        cmd(16'h0184, 16, 6'h0e);
        cmd(16'h0600, 8, 6'h0f);
        cmd(16'h0100, 16, 6'h0e);
        writeProtectN <= 1'b1;
        repeat (8) @(negedge clock);
        `CHK("status", 6'h0a, status)
        cmd(16'h0600, 8, 6'h0b);
        cmd(16'h0100, 16, 6'h00);
        cmd(16'h0600, 8, 6'h01);
        cmd(16'h0104, 16, 6'h02);
        arst_n <= 1'b0;
        repeat (2) @(negedge clock);
        arst_n <= 1'b1;
        repeat (5) @(negedge clock);
        `CHK("status", 6'h00, status)
        end_of_test();
    end
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule : fewp_flash_erase_write_protect_tb_top
